// ==== rtl/ssh_pkg.sv ====
`default_nettype none

package ssh_pkg;

  // clock and timing
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          I2C_QUARTER_NS  = 2500;
  localparam int          QDIV_W          = 9;
  localparam logic [QDIV_W-1:0] I2C_QUARTER_CYC =
    QDIV_W'((I2C_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          STRAP_INIT_NS   = 1000;
  localparam int          INIT_W          = 8;
  localparam logic [INIT_W-1:0] STRAP_INIT_CYC =
    INIT_W'((STRAP_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          SPEED_STRAP_BIT = 2;

  // register byte offsets
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_GPIO_OE     = 8'h04;
  localparam logic [7:0]  REG_GPIO_OUT    = 8'h08;
  localparam logic [7:0]  REG_GPIO_IN     = 8'h0c;
  localparam logic [7:0]  REG_GPIO_IRQ_EN = 8'h10;
  localparam logic [7:0]  REG_IRQ_STATUS  = 8'h14;
  localparam logic [7:0]  REG_IRQ_MASK    = 8'h18;
  localparam logic [7:0]  REG_STRAP       = 8'h1c;
  localparam logic [1:0]  REG_EXP_PAGE    = 2'h1;

  // control fields and reset values
  localparam int          CTRL_HP_EN      = 0;
  localparam int          CTRL_BASE_LSB   = 8;
  localparam logic        HP_EN_RST       = 1'b1;
  localparam logic [6:0]  EXP_BASE_RST    = 7'h20;

  // interrupt status bit positions
  localparam int          ST_W            = 9;
  localparam int          ST_HOTPLUG      = 0;
  localparam int          ST_LINK         = 1;
  localparam int          ST_GPIO         = 2;
  localparam int          ST_DEV_ERR      = 3;
  localparam int          ST_NT_LINK      = 4;
  localparam int          ST_NT_VDB       = 5;
  localparam int          ST_NT_LDB       = 6;
  localparam int          ST_FATAL        = 7;
  localparam int          ST_HP_NACK      = 8;
  localparam logic [ST_W-1:0] MASK_RST    = 9'h1ff;

  typedef enum logic [1:0] {I2C_START, I2C_WRITE, I2C_READ, I2C_STOP}
    ssh_i2c_op_e;

  typedef enum logic [2:0] {HP_IDLE, HP_START, HP_ADDR, HP_RD0, HP_RD1,
    HP_STOP} ssh_hp_state_e;

  // one-cycle event pulses from the switch core
  typedef struct packed {
    logic link_state;
    logic dev_err;
    logic nt_link;
    logic nt_vdb;
    logic nt_ldb;
    logic fatal;
  } ssh_core_evt_s;

endpackage

`default_nettype wire

// ==== rtl/ssh_sync.sv ====
`default_nettype none

module ssh_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      meta <= RST;
      q    <= RST;
    end
    else if (clk_en)
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/ssh_i2c_engine.sv ====
`default_nettype none

module ssh_i2c_engine
  import ssh_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic        cmd_valid,
  input  wire ssh_i2c_op_e cmd_op,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic        cmd_nack,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             busy,
  output logic             done,
  output logic [7:0]       rx_byte,
  output logic             ack_bit,
  output logic             scl_oe,
  output logic             sda_oe
);

  ssh_i2c_op_e       op;
  logic [1:0]        quarter;
  logic [3:0]        bit_n;
  logic [QDIV_W-1:0] div;
  logic [7:0]        shift;
  logic              nack;

  // pull sda low for bit n: data zero on write, ack on read
  function automatic logic data_low(input ssh_i2c_op_e o,
                                    input logic [3:0]  n,
                                    input logic        b,
                                    input logic        k);
    if (n == 4'd8)
      return (o == I2C_READ) && !k;
    return (o == I2C_WRITE) && !b;
  endfunction

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      busy    <= 1'b0;
      done    <= 1'b0;
      op      <= I2C_START;
      quarter <= 2'h0;
      bit_n   <= 4'h0;
      div     <= '0;
      shift   <= 8'h00;
      nack    <= 1'b0;
      rx_byte <= 8'h00;
      ack_bit <= 1'b0;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      if (!busy)
      begin
        if (cmd_valid)
        begin
          busy    <= 1'b1;
          op      <= cmd_op;
          quarter <= 2'h0;
          bit_n   <= 4'h0;
          div     <= I2C_QUARTER_CYC;
          shift   <= cmd_byte;
          nack    <= cmd_nack;
          unique case (cmd_op)
            I2C_START:
            begin
              scl_oe <= 1'b0;
              sda_oe <= 1'b0;
            end
            I2C_STOP:
            begin
              scl_oe <= 1'b1;
              sda_oe <= 1'b1;
            end
            I2C_WRITE, I2C_READ:
            begin
              scl_oe <= 1'b1;
              sda_oe <= data_low(cmd_op, 4'd0, cmd_byte[7], cmd_nack);
            end
          endcase
        end
      end
      else if (div != '0)
      begin
        // a released clock held low by an expander stretches the quarter
        if (scl_oe || scl_in)
          div <= div - 1'b1;
      end
      else
      begin
        div     <= I2C_QUARTER_CYC;
        quarter <= quarter + 2'd1;
        unique case (quarter)
          2'd0:
            if (op != I2C_START)
              scl_oe <= 1'b0; // RL1
          2'd1:
            if (op == I2C_START)
              sda_oe <= 1'b1; // RL2
            else if (op != I2C_STOP)
            begin
              if (bit_n == 4'd8)
                ack_bit <= sda_in; // RL2
              else
                rx_byte <= {rx_byte[6:0], sda_in}; // RL2
            end
          2'd2:
            if (op == I2C_STOP)
              sda_oe <= 1'b0; // RL2
            else
              scl_oe <= 1'b1; // RL1
          2'd3:
            if (op == I2C_START || op == I2C_STOP || bit_n == 4'd8)
            begin
              busy <= 1'b0;
              done <= 1'b1;
            end
            else
            begin
              bit_n  <= bit_n + 4'd1;
              shift  <= {shift[6:0], 1'b0};
              sda_oe <= data_low(op, bit_n + 4'd1, shift[6], nack); // RL2
            end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== rtl/ssh_sideband.sv ====
// Functional notes
// RL1: hot-plug controller masters the shared open-drain expander clock line.
// RL2: controller and expanders share one open-drain data line for transfers.
// RL3: expanders wire-AND their interrupts onto one active-low input line.
// RL4: low expander interrupt triggers reads of every expander's port registers.
// RL5: each general-purpose pin is input-only or bidirectional per its enable bit.
// RL6: fatal-error output goes low whenever a fatal error is detected.
// RL7: combined open-drain interrupt pulls low on any enabled event source.
// RL8: top test pin sampled at init: high caps 5.0 Gb/s, low 2.5 Gb/s.
// RL9: speed strap read only during init; pin then resumes its test role.
// RL10: combined interrupt releases only once all enabled pending sources clear.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`default_nettype none

module ssh_sideband
  import ssh_pkg::*;
#(
  parameter int N_EXP  = 4,
  parameter int GPIO_W = 8
) (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire ssh_core_evt_s     core_evt,
  input  wire logic              hotplug_serial_clock_i,
  output logic                   hotplug_serial_clock_o,
  output logic                   hotplug_serial_clock_oe,
  input  wire logic              hotplug_serial_data_i,
  output logic                   hotplug_serial_data_o,
  output logic                   hotplug_serial_data_oe,
  input  wire logic              hotplug_expander_irq_n,
  input  wire logic [GPIO_W-1:0] gpio_i,
  output logic      [GPIO_W-1:0] gpio_o,
  output logic      [GPIO_W-1:0] gpio_oe,
  input  wire logic [2:0]        test_strap_pins,
  output logic      [2:0]        test_mode_bits,
  output logic                   link_speed_gen2,
  output logic                   fatal_err_out_n,
  output logic                   combined_irq_out_n_o,
  output logic                   combined_irq_out_n_oe
);

  localparam int IDX_W = (N_EXP > 1) ? $clog2(N_EXP) : 1;

  // synchronised pins
  logic              scl_s;
  logic              sda_s;
  logic              exp_irq_n_s;
  logic [GPIO_W-1:0] gpio_s;
  logic [2:0]        strap_s;

  // software state
  logic              hp_enable;
  logic [6:0]        exp_base;
  logic [GPIO_W-1:0] gpio_irq_en;
  logic [GPIO_W-1:0] gpio_prev;
  logic [ST_W-1:0]   irq_status;
  logic [ST_W-1:0]   irq_mask;
  logic [ST_W-1:0]   status_set;
  logic [ST_W-1:0]   next_status;

  // strap capture
  logic [INIT_W-1:0] init_cnt;
  logic              init_done;

  // hot-plug scan
  ssh_hp_state_e     hp_state;
  logic [IDX_W-1:0]  exp_idx;
  logic [7:0]        port_lo;
  logic [15:0]       exp_port [N_EXP];
  logic              hp_change;
  logic              hp_nack;
  logic              eng_valid;
  ssh_i2c_op_e       eng_op;
  logic [7:0]        eng_byte;
  logic              eng_nack;
  logic              eng_busy;
  logic              eng_done;
  logic [7:0]        eng_rx;
  logic              eng_ack;

  // open-drain pins only ever pull low
  assign hotplug_serial_clock_o = 1'b0;
  assign hotplug_serial_data_o  = 1'b0;
  assign combined_irq_out_n_o   = 1'b0;

  ssh_sync #(
    .W   (2),
    .RST (2'b11)
  ) u_sync_i2c (
    .clock  (clock),
    .resetn (resetn),
    .clk_en (clk_en),
    .d      ({hotplug_serial_clock_i, hotplug_serial_data_i}),
    .q      ({scl_s, sda_s})
  );

  // idle level of the shared expander interrupt is high
  ssh_sync #(
    .W   (1),
    .RST (1'b1)
  ) u_sync_irq (
    .clock  (clock),
    .resetn (resetn),
    .clk_en (clk_en),
    .d      (hotplug_expander_irq_n),
    .q      (exp_irq_n_s)
  );

  ssh_sync #(
    .W   (GPIO_W),
    .RST ('0)
  ) u_sync_gpio (
    .clock  (clock),
    .resetn (resetn),
    .clk_en (clk_en),
    .d      (gpio_i),
    .q      (gpio_s)
  );

  ssh_sync #(
    .W   (3),
    .RST (3'h7)
  ) u_sync_strap (
    .clock  (clock),
    .resetn (resetn),
    .clk_en (clk_en),
    .d      (test_strap_pins),
    .q      (strap_s)
  );

  ssh_i2c_engine u_engine (
    .clock     (clock),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .cmd_valid (eng_valid),
    .cmd_op    (eng_op),
    .cmd_byte  (eng_byte),
    .cmd_nack  (eng_nack),
    .scl_in    (scl_s),
    .sda_in    (sda_s),
    .busy      (eng_busy),
    .done      (eng_done),
    .rx_byte   (eng_rx),
    .ack_bit   (eng_ack),
    .scl_oe    (hotplug_serial_clock_oe),
    .sda_oe    (hotplug_serial_data_oe)
  );

  // strap is sampled once at the end of init, then the pins go back to test
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      init_cnt        <= '0;
      init_done       <= 1'b0;
      link_speed_gen2 <= 1'b0;
      test_mode_bits  <= 3'h0;
    end
    else if (clk_en)
    begin
      if (!init_done)
      begin
        if (init_cnt == STRAP_INIT_CYC - 1'b1)
        begin
          init_done       <= 1'b1;
          link_speed_gen2 <= strap_s[SPEED_STRAP_BIT]; // RL8
        end
        else
          init_cnt <= init_cnt + 1'b1;
      end
      else
        test_mode_bits <= strap_s; // RL9
    end
  end

  // hot-plug scan: start, address+read, two port bytes, stop, per expander
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      hp_state  <= HP_IDLE;
      exp_idx   <= '0;
      port_lo   <= 8'h00;
      hp_change <= 1'b0;
      hp_nack   <= 1'b0;
      eng_valid <= 1'b0;
      eng_op    <= I2C_START;
      eng_byte  <= 8'h00;
      eng_nack  <= 1'b0;
      for (int i = 0; i < N_EXP; i++)
        exp_port[i] <= 16'h0000;
    end
    else if (clk_en)
    begin
      eng_valid <= 1'b0;
      hp_change <= 1'b0;
      hp_nack   <= 1'b0;
      unique case (hp_state)
        HP_IDLE:
          // the line stays low until every expander has been read
          if (init_done && hp_enable && !exp_irq_n_s) // RL3 RL4
          begin
            exp_idx   <= '0;
            eng_op    <= I2C_START;
            eng_valid <= 1'b1;
            hp_state  <= HP_START;
          end
        HP_START:
          if (eng_done)
          begin
            eng_op    <= I2C_WRITE;
            eng_byte  <= {7'(exp_base + 7'(exp_idx)), 1'b1}; // RL4
            eng_valid <= 1'b1;
            hp_state  <= HP_ADDR;
          end
        HP_ADDR:
          if (eng_done)
          begin
            eng_valid <= 1'b1;
            if (eng_ack)
            begin
              // absent expander: report and skip it
              hp_nack  <= 1'b1;
              eng_op   <= I2C_STOP;
              hp_state <= HP_STOP;
            end
            else
            begin
              eng_op   <= I2C_READ;
              eng_nack <= 1'b0;
              hp_state <= HP_RD0;
            end
          end
        HP_RD0:
          if (eng_done)
          begin
            port_lo   <= eng_rx;
            eng_op    <= I2C_READ;
            eng_nack  <= 1'b1;
            eng_valid <= 1'b1;
            hp_state  <= HP_RD1;
          end
        HP_RD1:
          if (eng_done)
          begin
            exp_port[exp_idx] <= {eng_rx, port_lo}; // RL4
            hp_change <= (exp_port[exp_idx] != {eng_rx, port_lo});
            eng_op    <= I2C_STOP;
            eng_valid <= 1'b1;
            hp_state  <= HP_STOP;
          end
        HP_STOP:
          if (eng_done)
          begin
            if (exp_idx == IDX_W'(N_EXP - 1))
              hp_state <= HP_IDLE;
            else
            begin
              exp_idx   <= exp_idx + 1'b1;
              eng_op    <= I2C_START;
              eng_valid <= 1'b1;
              hp_state  <= HP_START;
            end
          end
      endcase
    end
  end

  // software-owned controls
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      hp_enable   <= HP_EN_RST;
      exp_base    <= EXP_BASE_RST;
      gpio_oe     <= '0;
      gpio_o      <= '0;
      gpio_irq_en <= '0;
      irq_mask    <= MASK_RST;
    end
    else if (clk_en && reg_wr)
    begin
      unique case (reg_addr)
        REG_CTRL:
        begin
          hp_enable <= reg_wdata[CTRL_HP_EN];
          exp_base  <= reg_wdata[CTRL_BASE_LSB +: 7];
        end
        REG_GPIO_OE:     gpio_oe     <= reg_wdata[GPIO_W-1:0]; // RL5
        REG_GPIO_OUT:    gpio_o      <= reg_wdata[GPIO_W-1:0];
        REG_GPIO_IRQ_EN: gpio_irq_en <= reg_wdata[GPIO_W-1:0];
        REG_IRQ_MASK:    irq_mask    <= reg_wdata[ST_W-1:0];
        default:
        begin
        end
      endcase
    end
  end

  // input change is an event only on pins left as inputs
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      gpio_prev <= '0;
    else if (clk_en)
      gpio_prev <= gpio_s;
  end

  always_comb
  begin
    status_set             = '0;
    status_set[ST_HOTPLUG] = hp_change;
    status_set[ST_LINK]    = core_evt.link_state;
    status_set[ST_GPIO]    = |((gpio_s ^ gpio_prev) & gpio_irq_en & ~gpio_oe);
    status_set[ST_DEV_ERR] = core_evt.dev_err;
    status_set[ST_NT_LINK] = core_evt.nt_link;
    status_set[ST_NT_VDB]  = core_evt.nt_vdb;
    status_set[ST_NT_LDB]  = core_evt.nt_ldb;
    status_set[ST_FATAL]   = core_evt.fatal;
    status_set[ST_HP_NACK] = hp_nack;
    // an event landing on the clearing read survives it
    if (reg_rd && reg_addr == REG_IRQ_STATUS)
      next_status = status_set;
    else
      next_status = irq_status | status_set;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_status            <= '0;
      fatal_err_out_n       <= 1'b1;
      combined_irq_out_n_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_status            <= next_status;
      fatal_err_out_n       <= !next_status[ST_FATAL]; // RL6
      combined_irq_out_n_oe <= |(next_status & irq_mask); // RL7 RL10
    end
  end

  // read data stand one cycle only, zero otherwise and for holes
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 32'h0000_0000;
    else if (clk_en)
    begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd)
      begin
        unique case (reg_addr)
          REG_CTRL:
          begin
            reg_rdata[CTRL_HP_EN]           <= hp_enable;
            reg_rdata[CTRL_BASE_LSB +: 7]   <= exp_base;
          end
          REG_GPIO_OE:     reg_rdata[GPIO_W-1:0] <= gpio_oe;
          REG_GPIO_OUT:    reg_rdata[GPIO_W-1:0] <= gpio_o;
          REG_GPIO_IN:     reg_rdata[GPIO_W-1:0] <= gpio_s;
          REG_GPIO_IRQ_EN: reg_rdata[GPIO_W-1:0] <= gpio_irq_en;
          REG_IRQ_STATUS:  reg_rdata[ST_W-1:0]   <= irq_status;
          REG_IRQ_MASK:    reg_rdata[ST_W-1:0]   <= irq_mask;
          REG_STRAP:
            reg_rdata[3:0] <= {hp_state != HP_IDLE, eng_busy, init_done,
                               link_speed_gen2};
          default:
            if (reg_addr[7:6] == REG_EXP_PAGE
                && 32'(reg_addr[5:2]) < N_EXP)
              reg_rdata[15:0] <= exp_port[IDX_W'(reg_addr[5:2])];
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== bench/ssh_sideband_chk.sv ====
`default_nettype none

module ssh_sideband_chk
  import ssh_pkg::*;
#(
  parameter int GPIO_W = 8
) (
  input wire logic              clock,
  input wire logic              resetn,
  input wire logic              clk_en,
  input wire logic [7:0]        reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire ssh_core_evt_s     core_evt,
  input wire logic              hotplug_serial_clock_oe,
  input wire logic              hotplug_serial_data_oe,
  input wire logic              hotplug_expander_irq_n,
  input wire logic [GPIO_W-1:0] gpio_oe,
  input wire logic [2:0]        test_strap_pins,
  input wire logic [2:0]        test_mode_bits,
  input wire logic              link_speed_gen2,
  input wire logic              fatal_err_out_n,
  input wire logic              combined_irq_out_n_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      cnt <= 8'h00;
    else if (clk_en && cnt != 8'hff)
      cnt <= cnt + 8'h01;

  chk_scl_low_hold:
    assert property ($rose(hotplug_serial_clock_oe)
      |=> hotplug_serial_clock_oe [*8])
    else $error("serial clock low phase too short");
  chk_scan_start:
    assert property ($fell(hotplug_expander_irq_n) &&
      !hotplug_serial_clock_oe && !hotplug_serial_data_oe
      |-> ##[1:700] $rose(hotplug_serial_data_oe) && !hotplug_serial_clock_oe)
    else $error("expander interrupt did not start a scan");
  chk_gpio_dir:
    assert property (clk_en && reg_wr && reg_addr == REG_GPIO_OE
      |=> gpio_oe == $past(reg_wdata[GPIO_W-1:0]))
    else $error("pin enables do not follow the write");
  chk_fatal_drive:
    assert property (clk_en && core_evt.fatal |=> !fatal_err_out_n)
    else $error("fatal output not driven low");
  chk_fatal_hold:
    assert property (!fatal_err_out_n &&
      !(reg_rd && reg_addr == REG_IRQ_STATUS) |=> !fatal_err_out_n)
    else $error("fatal output released without status read");
  chk_irq_event:
    assert property (clk_en && |core_evt |=> combined_irq_out_n_oe)
    else $error("combined interrupt not pulled low on event");
  chk_irq_release:
    assert property ($fell(combined_irq_out_n_oe)
      |-> $past(reg_rd && reg_addr == REG_IRQ_STATUS) ||
          $past(reg_wr && reg_addr == REG_IRQ_MASK))
    else $error("combined interrupt released with sources pending");
  chk_strap_sample:
    assert property (cnt == 8'd140
      |-> link_speed_gen2 == $past(test_strap_pins[2], 20))
    else $error("speed cap does not match strap");
  chk_strap_freeze:
    assert property (cnt > 8'd140 |-> $stable(link_speed_gen2))
    else $error("speed cap changed after init");
  chk_strap_hide:
    assert property (cnt < 8'd100 |-> test_mode_bits == 3'h0)
    else $error("test pins visible during init");

  cover property ($rose(hotplug_serial_data_oe) && !hotplug_serial_clock_oe);
  cover property ($fell(fatal_err_out_n));
  cover property ($rose(combined_irq_out_n_oe));
endmodule

bind ssh_sideband ssh_sideband_chk #(.GPIO_W(GPIO_W)) chk_u (
  .clock, .resetn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .core_evt, .hotplug_serial_clock_oe, .hotplug_serial_data_oe,
  .hotplug_expander_irq_n, .gpio_oe, .test_strap_pins, .test_mode_bits,
  .link_speed_gen2, .fatal_err_out_n, .combined_irq_out_n_oe);

`default_nettype wire

// ==== bench/ssh_exp_model.sv ====
`default_nettype none

// one slot expander: answers reads at its address, no clock stretching
module ssh_exp_model
  import ssh_pkg::*;
#(
  parameter logic [6:0] ADDR = EXP_BASE_RST
) (
  input  wire logic        scl,
  input  wire logic        sda,
  input  wire logic [15:0] port_val,
  input  wire logic        raise,
  output logic             sda_oe,
  output logic             irq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] bitn = 4'h0;
  logic [7:0] sh   = 8'h00;
  logic [1:0] ph   = 2'h0;
  logic       hit  = 1'b0;
  logic       mack = 1'b0;

  initial
  begin
    sda_oe = 1'b0;
    irq_n = 1'b1;
  end
  always @(posedge raise) irq_n = 1'b0;
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      ph = 2'h1;
      bitn = 4'hf;
      hit = 1'b0;
    end
  always @(posedge sda)
    if (scl === 1'b1)
    begin
      ph = 2'h0;
      sda_oe = 1'b0;
    end
  always @(posedge scl)
    if (ph == 2'h1 && bitn < 4'h8)
      sh = {sh[6:0], sda};
    else if (ph == 2'h2 && bitn == 4'h8)
      mack = !sda;
  // data only changes while the clock is low, so no false start or stop
  always @(negedge scl)
    if (ph != 2'h0)
    begin
      bitn = (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
      if (ph == 2'h1 && bitn == 4'h8)
      begin
        hit = (sh == {ADDR, 1'b1});
        sda_oe = hit;
        if (!hit)
          ph = 2'h0;
      end
      else if (ph == 2'h1 && bitn == 4'h0 && hit)
      begin
        ph = 2'h2;
        sh = port_val[7:0];
      end
      else if (ph == 2'h2 && bitn == 4'h0 && mack)
        sh = port_val[15:8];
      else if (ph == 2'h2 && bitn == 4'h0)
      begin
        ph = 2'h0;
        sda_oe = 1'b0;
        irq_n = 1'b1;
      end
      if (ph == 2'h2)
        sda_oe = (bitn == 4'h8) ? 1'b0 : !sh[3'd7 - bitn[2:0]];
    end
endmodule

`default_nettype wire

// ==== bench/ssh_sideband_test.sv ====
`default_nettype none

module ssh_sideband_test
  import ssh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clock     = 1'b0;
  logic          resetn    = 1'b0;
  logic [7:0]    reg_addr  = 8'h00;
  logic [31:0]   reg_wdata = 32'h0;
  logic          reg_wr    = 1'b0;
  logic          reg_rd    = 1'b0;
  ssh_core_evt_s core_evt  = '0;
  logic          raise     = 1'b0;
  logic [7:0]    gpio_ext  = 8'h00;
  logic [2:0]    strap     = 3'h7;
  logic [31:0]   reg_rdata;
  logic [7:0]    gpio_o, gpio_oe, gpio_pin;
  logic [2:0]    test_mode_bits;
  logic          scl_oe, sda_oe, exp_sda_oe, irq_n, scl, sda;
  logic          link_speed_gen2, fatal_n, irq_oe;
  int            miscompares = 0, checked = 0;

  assign scl = !scl_oe;
  assign sda = !(sda_oe | exp_sda_oe);
  assign gpio_pin = (gpio_oe & gpio_o) | (~gpio_oe & gpio_ext);
  always #4 clock = ~clock;

  ssh_sideband #(.N_EXP(2)) dut_u (
    .clock(clock), .resetn(resetn), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_evt(core_evt),
    .hotplug_serial_clock_i(scl), .hotplug_serial_clock_o(),
    .hotplug_serial_clock_oe(scl_oe), .hotplug_serial_data_i(sda),
    .hotplug_serial_data_o(), .hotplug_serial_data_oe(sda_oe),
    .hotplug_expander_irq_n(irq_n), .gpio_i(gpio_pin), .gpio_o(gpio_o),
    .gpio_oe(gpio_oe), .test_strap_pins(strap),
    .test_mode_bits(test_mode_bits), .link_speed_gen2(link_speed_gen2),
    .fatal_err_out_n(fatal_n), .combined_irq_out_n_o(),
    .combined_irq_out_n_oe(irq_oe));

  // only the first expander is fitted, the second address goes unanswered
  ssh_exp_model exp_u (.scl(scl), .sda(sda), .port_val(16'h1234),
    .raise(raise), .sda_oe(exp_sda_oe), .irq_n(irq_n));

  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rchk(input string n, logic [7:0] a, logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic do_reset(input logic [2:0] s);
    @(posedge clock);
    strap <= s;
    resetn <= 1'b0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    settle(150);
  endtask
  task automatic test_strap(input logic e);
    chk("speed cap", 32'(e), 32'(link_speed_gen2));
    rchk("strap reg", REG_STRAP, {30'h0, 1'b1, e});
    @(posedge clock);
    strap <= strap ^ 3'h4;
    settle(10);
    chk("speed held", 32'(e), 32'(link_speed_gen2));
    chk("test pins", 32'(strap), 32'(test_mode_bits));
  endtask
  task automatic test_gpio();
    wr(REG_GPIO_OE, 32'h0f);
    chk("pin enables", 32'h0f, 32'(gpio_oe));
    wr(REG_GPIO_OUT, 32'h05);
    @(posedge clock);
    gpio_ext <= 8'ha0;
    settle(6);
    rchk("pin levels", REG_GPIO_IN, 32'ha5);
    rchk("unmapped", 8'h80, 32'h0);
    rchk("ctrl reset", REG_CTRL, 32'h2001);
  endtask
  task automatic test_irq();
    wr(REG_GPIO_IRQ_EN, 32'h80);
    wr(REG_IRQ_MASK, 32'h1fb);
    @(posedge clock);
    gpio_ext <= 8'h20;
    settle(6);
    chk("masked irq", 32'h0, 32'(irq_oe));
    rchk("status", REG_IRQ_STATUS, 32'h4);
    wr(REG_IRQ_MASK, 32'h1ff);
    @(posedge clock);
    gpio_ext <= 8'ha0;
    settle(6);
    chk("gpio irq", 32'h1, 32'(irq_oe));
    rchk("status", REG_IRQ_STATUS, 32'h4);
    chk("irq cleared", 32'h0, 32'(irq_oe));
  endtask
  task automatic test_events();
    int pos[6] = '{ST_FATAL, ST_NT_LDB, ST_NT_VDB, ST_NT_LINK, ST_DEV_ERR,
                   ST_LINK};
    for (int j = 0; j < 6; j++)
    begin
      @(posedge clock);
      core_evt <= ssh_core_evt_s'(6'h1 << j);
      @(posedge clock);
      core_evt <= '0;
      #1;
      chk("event irq", 32'h1, 32'(irq_oe));
      chk("fatal out", 32'(j != 0), 32'(fatal_n));
      rchk("status", REG_IRQ_STATUS, 32'h1 << pos[j]);
      chk("irq cleared", 32'h0, 32'(irq_oe));
      chk("fatal cleared", 32'h1, 32'(fatal_n));
    end
  endtask
  task automatic test_hotplug();
    logic [31:0] d;
    @(posedge clock);
    raise <= 1'b1;
    @(posedge clock);
    raise <= 1'b0;
    repeat (200)
    begin
      settle(300);
      rd(REG_STRAP, d);
      if (d[3] === 1'b0 && irq_n === 1'b1)
        break;
    end
    chk("expander irq", 32'h1, 32'(irq_n));
    rchk("port 0", 8'h40, 32'h1234);
    rchk("status", REG_IRQ_STATUS, 32'h101);
    chk("irq cleared", 32'h0, 32'(irq_oe));
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // the scan of two expanders dominates, about 400 us
  initial
  begin
    #700000;
    miscompares++;
    results();
  end
  initial
  begin
    do_reset(3'h7);
    test_strap(1'b1);
    test_gpio();
    test_irq();
    test_events();
    test_hotplug();
    do_reset(3'h3);
    test_strap(1'b0);
    results();
  end
endmodule

`default_nettype wire
